// ---- hw/rsp_fifo.sv ----
// Ordered response queue with a registered head word for the host.
// Assumes the writer checks full before pushing and the host pops only a valid head.
`timescale 1ns/1ps

module rsp_fifo
  import trib_event_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16
) (
  input wire logic mclk_i, // Controller clock.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic push_i, // Write one word.
  input wire logic [WIDTH-1:0] push_data_i, // Word to write.
  output logic full_o, // No room in storage.
  output logic room2_o, // At least two free slots.
  output logic head_valid_o, // Head word is valid.
  output logic [WIDTH-1:0] head_o, // Head word.
  input wire logic pop_i // Host has consumed the head word.
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH]; // Storage behind the head register.
  logic [AW-1:0] wr_q; // Write pointer.
  logic [AW-1:0] rd_q; // Read pointer.
  logic [AW:0] cnt_q; // Words in storage.
  logic load; // Head register takes a word this cycle.

  // The head refills whenever storage holds a word and the head is empty or being consumed.
  assign load = (cnt_q != '0) && (!head_valid_o || pop_i);

  // Storage write; a full queue refuses the word so nothing is overwritten.
  always_ff @(posedge mclk_i) begin
    if (push_i && !full_o) begin
      mem_q[wr_q] <= push_data_i;
    end
  end

  // Pointers and count.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push_i && !full_o) begin
        wr_q <= AW'((wr_q + 1'b1) % DEPTH);
      end
      if (load) begin
        rd_q <= AW'((rd_q + 1'b1) % DEPTH);
      end
      cnt_q <= cnt_q + (AW+1)'(push_i && !full_o) - (AW+1)'(load);
    end
  end

  // Flags from the next count so they stand as flip-flops.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      full_o <= 1'b0;
      room2_o <= 1'b1;
    end else begin
      full_o <= (cnt_q + (AW+1)'(push_i && !full_o) - (AW+1)'(load)) == (AW+1)'(DEPTH);
      room2_o <= (cnt_q + (AW+1)'(push_i && !full_o) - (AW+1)'(load)) <= (AW+1)'(DEPTH - 2);
    end
  end

  // Head register shown to the host until popped.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      head_valid_o <= 1'b0;
      head_o <= '0;
    end else if (load) begin
      head_valid_o <= 1'b1;
      head_o <= mem_q[rd_q];
    end else if (pop_i) begin
      head_valid_o <= 1'b0;
    end
  end

  // A valid head stays put until the host pops it.
  chk_head_holds: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    head_valid_o && !pop_i |=> head_valid_o && $stable(head_o))
    else $error("Response head changed before the host consumed it.");

endmodule

// ---- hw/sel_interval_timer.sv ----
// Selection interval timer: one outstanding poll or transmission at a time.
// Assumes start and response strobes come from logic on the same clock.
`timescale 1ns/1ps

module sel_interval_timer
  import trib_event_pkg::*;
#(
  parameter int INTERVAL_CYC = 25000
) (
  input wire logic mclk_i, // Controller clock.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic start_i, // Poll or transmission ends, interval opens.
  input wire logic [7:0] start_addr_i, // Station being waited on.
  input wire logic resp_i, // Station answered, interval closes.
  output logic timeout_o, // One-cycle pulse: interval expired.
  output logic [7:0] timeout_addr_o // Station that failed to answer.
);

  logic run_q; // Interval is open.
  logic [31:0] cnt_q; // Cycles elapsed in the open interval.

  // A new start restarts the interval; an answer closes it without a timeout.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= 1'b0;
      cnt_q <= 32'h0;
      timeout_addr_o <= 8'h00;
    end else if (start_i) begin
      run_q <= 1'b1;
      cnt_q <= 32'h0;
      timeout_addr_o <= start_addr_i;
    end else if (resp_i) begin
      run_q <= 1'b0;
    end else if (run_q) begin
      if (cnt_q == 32'(INTERVAL_CYC - 1)) begin
        run_q <= 1'b0;
      end
      cnt_q <= cnt_q + 32'h1;
    end
  end

  // The pulse is registered so that the parent sees it with the address already stable.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= run_q && !start_i && !resp_i && (cnt_q == 32'(INTERVAL_CYC - 1));
    end
  end

  // A timeout never fires before the full interval has run.
  chk_timeout_late: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    timeout_o |-> $past(cnt_q) == 32'(INTERVAL_CYC - 1))
    else $error("Selection timeout fired before the interval ended.");

endmodule

// ---- hw/trib_event_defines.svh ----
// Constants for the tributary event response logic: event codes, limits and timing.
// Assumes it is included by bare name from the package, the top design module and the bench.
`ifndef TRIB_EVENT_DEFINES_SVH
`define TRIB_EVENT_DEFINES_SVH

// Response codes, octal 006/010/012/014/016/022 written in hexadecimal.
`define TEV_CODE_SEL_THRESH 8'h06
`define TEV_CODE_START_RUN 8'h08
`define TEV_CODE_MAINT_RUN 8'h0A
`define TEV_CODE_MAINT_HALT 8'h0C
`define TEV_CODE_START_MAINT 8'h0E
`define TEV_CODE_POLL_DEAD 8'h12

// Selection timeouts that make one select threshold error.
`define TEV_SEL_LIMIT 3'h7
`define TEV_SEL_CNT_ZERO 3'h0
`define TEV_SEL_CNT_ONE 3'h1

// Clock period and selection interval, both in nanoseconds.
`define TEV_CLK_PERIOD_NS 40
`define TEV_SEL_INTERVAL_NS 1000000

// Default widths and depths.
`define TEV_ADDR_W 8
`define TEV_FIFO_DEPTH 8

`endif

// ---- hw/trib_event_pkg.sv ----
// Types shared by the tributary event response logic.
// Assumes the defines header is on the include path.
`include "trib_event_defines.svh"

package trib_event_pkg;

  // Tributary protocol state.
  typedef enum logic [2:0] {
    ST_HALTED = 3'b000,
    ST_ISTRT = 3'b001,
    ST_ASTRT = 3'b010,
    ST_RUN = 3'b011,
    ST_MAINT = 3'b100
  } trib_state_type;

  // Kind of received message that the event logic cares about.
  typedef enum logic [0:0] {
    MSG_START = 1'b0,
    MSG_MAINT = 1'b1
  } msg_kind_type;

  // One unsolicited control response: address byte and response code byte.
  typedef struct packed {
    logic [7:0] tributary_address_byte;
    logic [7:0] response_code_byte;
  } event_rsp_type;

  // Received message as handed over by the receiver.
  typedef struct packed {
    logic [7:0] addr;
    msg_kind_type kind;
  } rx_msg_type;

endpackage

// ---- hw/tributary_event_response_logic.sv ----
// Event reporting for a multipoint link controller: per-tributary protocol state,
// select threshold counting and a queue of unsolicited control responses.
// Assumes receiver, poller and host command decoder share mclk_i.
`timescale 1ns/1ps
`include "trib_event_defines.svh"

// How it works
// - Seventh selection timeout posts code 006.
// - Reporting clears that station's selection counter.
// - Timer bounds the wait for station answer.
// - Start in run posts code 010.
// - Then halt tributary and return buffers.
// - Maintenance while running/starting posts 012, halts, discards.
// - That tributary then enters maintenance state.
// - Maintenance while halted posts 014, enters maintenance.
// - Start in maintenance posts 016 only.
// - Control station posts 022 on dead polling.
// - No dead polling event point-to-point.
// - Response carries address byte and code byte.
module tributary_event_response_logic
#(
  parameter int ADDR_W = `TEV_ADDR_W,
  parameter int FIFO_DEPTH = `TEV_FIFO_DEPTH,
  parameter int SEL_INTERVAL_CYC = `TEV_SEL_INTERVAL_NS / `TEV_CLK_PERIOD_NS
) (
  input wire logic mclk_i, // Controller clock, 25 MHz.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic rx_valid_i, // Received start or maintenance message.
  input wire trib_event_pkg::rx_msg_type rx_msg_i, // Its address and kind.
  output logic rx_ready_o, // Message can be taken this cycle.
  input wire logic poll_start_i, // Poll or transmission just ended.
  input wire logic [7:0] poll_addr_i, // Station being waited on.
  input wire logic poll_resp_i, // Station answered in time.
  input wire logic poll_dead_i, // Polling state of a tributary went dead.
  input wire logic [7:0] poll_dead_addr_i, // That tributary.
  input wire logic control_station_i, // This station is the control station.
  input wire logic multipoint_i, // Multipoint operation, low for point-to-point.
  input wire logic startup_cmd_i, // Host request start-up state command.
  input wire logic ack_start_i, // Start acknowledge seen, move to ASTRT.
  input wire logic link_up_i, // Start-up sequence complete, move to run.
  input wire logic [7:0] cmd_addr_i, // Tributary of the three strobes above.
  output logic halt_o, // Pulse: halt protocol, return all buffers.
  output logic [7:0] halt_addr_o, // Tributary being halted.
  output logic discard_o, // Pulse: drop the message just taken.
  output logic rsp_valid_o, // Control response waiting for the host.
  output trib_event_pkg::event_rsp_type rsp_o, // Address byte and code byte.
  input wire logic rsp_pop_i // Host has read the response.
);
  import trib_event_pkg::*;

  localparam int NTRIB = 2 ** ADDR_W;

  trib_state_type state_q [NTRIB]; // Protocol state per tributary.
  logic [2:0] sel_cnt_q [NTRIB]; // Selection timeouts per station.
  logic sel_to; // Timer pulse.
  logic [7:0] sel_to_addr; // Station that timed out.
  logic sel_hit; // This timeout is the seventh.
  logic sel_pend_q; // Select threshold response waiting for a queue slot.
  logic [7:0] sel_addr_q; // Its address.
  logic dead_pend_q; // Dead polling response waiting for a queue slot.
  logic [7:0] dead_addr_q; // Its address.
  logic dead_ev; // Dead polling event that is meaningful here.
  logic rx_take; // Message accepted this cycle.
  trib_state_type rx_state; // State of the addressed tributary.
  logic ev_post; // Received message makes a response.
  logic [7:0] ev_code; // Its code.
  logic ev_halt; // It halts the tributary.
  logic ev_discard; // It is dropped.
  trib_state_type ev_next; // State it leaves behind.
  logic [2:0] ev_next_bits; // Raw state bits from the decode, cast back to the state type.
  logic push; // Queue write.
  event_rsp_type push_data; // Queue word.
  logic fifo_full; // Queue storage full.
  logic fifo_room2; // Queue has two free slots.
  logic push_sel; // Pending select response goes this cycle.
  logic push_dead; // Pending dead response goes this cycle.

  // Pure decode of what a received message does in a given state.
  function automatic logic [13:0] decode_event(input msg_kind_type kind, input trib_state_type st);
    logic [13:0] r;
    r = {1'b0, 8'h00, 1'b0, 1'b0, st};
    if (kind == MSG_START && st == ST_RUN) begin
      r = {1'b1, `TEV_CODE_START_RUN, 1'b1, 1'b0, ST_HALTED};
    end else if (kind == MSG_START && st == ST_MAINT) begin
      r = {1'b1, `TEV_CODE_START_MAINT, 1'b0, 1'b0, st};
    end else if (kind == MSG_MAINT && (st == ST_RUN || st == ST_ISTRT || st == ST_ASTRT)) begin
      r = {1'b1, `TEV_CODE_MAINT_RUN, 1'b1, 1'b1, ST_MAINT};
    end else if (kind == MSG_MAINT && st == ST_HALTED) begin
      r = {1'b1, `TEV_CODE_MAINT_HALT, 1'b0, 1'b1, ST_MAINT};
    end
    return r;
  endfunction

  // Messages are only taken when the queue can still hold their response.
  assign rx_take = rx_valid_i && rx_ready_o;
  assign rx_state = state_q[rx_msg_i.addr];
  assign {ev_post, ev_code, ev_halt, ev_discard, ev_next_bits} = decode_event(rx_msg_i.kind, rx_state);
  assign ev_next = trib_state_type'(ev_next_bits);
  assign sel_hit = sel_to && (sel_cnt_q[sel_to_addr] == `TEV_SEL_LIMIT - `TEV_SEL_CNT_ONE);
  assign dead_ev = poll_dead_i && control_station_i && multipoint_i;

  // One queue write per cycle: received message first, then select, then dead polling.
  always_comb begin
    push_sel = 1'b0;
    push_dead = 1'b0;
    push = 1'b0;
    push_data = '0;
    if (rx_take && ev_post) begin
      push = 1'b1;
      push_data = '{tributary_address_byte: rx_msg_i.addr, response_code_byte: ev_code};
    end else if (sel_pend_q && !fifo_full) begin
      push = 1'b1;
      push_sel = 1'b1;
      push_data = '{tributary_address_byte: sel_addr_q, response_code_byte: `TEV_CODE_SEL_THRESH};
    end else if (dead_pend_q && !fifo_full) begin
      push = 1'b1;
      push_dead = 1'b1;
      push_data = '{tributary_address_byte: dead_addr_q, response_code_byte: `TEV_CODE_POLL_DEAD};
    end
  end

  // Selection interval timer for the one outstanding poll.
  sel_interval_timer #(
    .INTERVAL_CYC(SEL_INTERVAL_CYC)
  ) u_sel_timer (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .start_i(poll_start_i),
    .start_addr_i(poll_addr_i),
    .resp_i(poll_resp_i),
    .timeout_o(sel_to),
    .timeout_addr_o(sel_to_addr)
  );

  // Ordered response queue toward the host.
  rsp_fifo #(
    .DEPTH(FIFO_DEPTH),
    .WIDTH($bits(event_rsp_type))
  ) u_rsp_fifo (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .push_i(push),
    .push_data_i(push_data),
    .full_o(fifo_full),
    .room2_o(fifo_room2),
    .head_valid_o(rsp_valid_o),
    .head_o(rsp_o),
    .pop_i(rsp_pop_i)
  );

  // Tributary states: received messages override host strobes in the same cycle.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NTRIB; i++) begin
        state_q[i] <= ST_HALTED;
      end
    end else begin
      if (startup_cmd_i && (state_q[cmd_addr_i] == ST_HALTED || state_q[cmd_addr_i] == ST_MAINT)) begin
        state_q[cmd_addr_i] <= ST_ISTRT;
      end else if (ack_start_i && state_q[cmd_addr_i] == ST_ISTRT) begin
        state_q[cmd_addr_i] <= ST_ASTRT;
      end else if (link_up_i && (state_q[cmd_addr_i] == ST_ISTRT || state_q[cmd_addr_i] == ST_ASTRT)) begin
        state_q[cmd_addr_i] <= ST_RUN;
      end
      if (rx_take) begin
        state_q[rx_msg_i.addr] <= ev_next;
      end
    end
  end

  // Selection error counters; the seventh timeout reports and clears.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NTRIB; i++) begin
        sel_cnt_q[i] <= `TEV_SEL_CNT_ZERO;
      end
    end else if (sel_hit) begin
      sel_cnt_q[sel_to_addr] <= `TEV_SEL_CNT_ZERO;
    end else if (sel_to) begin
      sel_cnt_q[sel_to_addr] <= sel_cnt_q[sel_to_addr] + `TEV_SEL_CNT_ONE;
    end
  end

  // Pending events: a new event wins over the clear caused by its predecessor's push.
  // Limitation: a second threshold while one is still pending replaces the older address.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_pend_q <= 1'b0;
      sel_addr_q <= 8'h00;
    end else if (sel_hit) begin
      sel_pend_q <= 1'b1;
      sel_addr_q <= sel_to_addr;
    end else if (push_sel) begin
      sel_pend_q <= 1'b0;
    end
  end

  // Dead polling pending slot, same policy as the select slot.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dead_pend_q <= 1'b0;
      dead_addr_q <= 8'h00;
    end else if (dead_ev) begin
      dead_pend_q <= 1'b1;
      dead_addr_q <= poll_dead_addr_i;
    end else if (push_dead) begin
      dead_pend_q <= 1'b0;
    end
  end

  // Halt and discard strobes for the buffer return and receive paths.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      halt_o <= 1'b0;
      halt_addr_o <= 8'h00;
      discard_o <= 1'b0;
    end else begin
      halt_o <= rx_take && ev_halt;
      discard_o <= rx_take && ev_discard;
      if (rx_take && ev_halt) begin
        halt_addr_o <= rx_msg_i.addr;
      end
    end
  end

  // Ready keeps two slots free so a message response and a pending one both fit.
  // Trade-off: the last storage slot is mostly held back for select and dead events.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_ready_o <= 1'b0;
    end else begin
      rx_ready_o <= fifo_room2;
    end
  end

  // A start in run halts that tributary and names it on the halt strobe.
  chk_start_run_halt: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rx_take && rx_msg_i.kind == MSG_START && rx_state == ST_RUN
    |=> halt_o && halt_addr_o == $past(rx_msg_i.addr) && state_q[$past(rx_msg_i.addr)] == ST_HALTED)
    else $error("Start in run did not halt the tributary.");

  // The same start queues its event code in the cycle it is taken.
  chk_start_run_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rx_take && rx_msg_i.kind == MSG_START && rx_state == ST_RUN
    |-> push && push_data.response_code_byte == `TEV_CODE_START_RUN)
    else $error("Start in run did not post its code.");

  // Maintenance while running or starting halts, discards and parks in maintenance.
  chk_maint_run_path: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rx_take && rx_msg_i.kind == MSG_MAINT && (rx_state == ST_RUN || rx_state == ST_ISTRT || rx_state == ST_ASTRT)
    |=> halt_o && discard_o && state_q[$past(rx_msg_i.addr)] == ST_MAINT)
    else $error("Maintenance while running was not handled.");

  // A halted tributary enters maintenance without a second halt.
  chk_maint_halted: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rx_take && rx_msg_i.kind == MSG_MAINT && rx_state == ST_HALTED
    |=> !halt_o && discard_o && state_q[$past(rx_msg_i.addr)] == ST_MAINT)
    else $error("Maintenance while halted was not handled.");

  // Start in maintenance only reports; the state is left alone.
  chk_start_maint_keep: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rx_take && rx_msg_i.kind == MSG_START && rx_state == ST_MAINT
    |-> push_data.response_code_byte == `TEV_CODE_START_MAINT ##1 !halt_o && !discard_o)
    else $error("Start in maintenance did more than report.");

  // The seventh timeout both arms the report and clears the counter.
  chk_sel_threshold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    sel_hit |=> sel_pend_q && sel_cnt_q[$past(sel_to_addr)] == `TEV_SEL_CNT_ZERO)
    else $error("Select threshold did not post and clear.");

  // Point-to-point lines never arm a dead polling report.
  chk_dead_p2p: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    poll_dead_i && !multipoint_i && !dead_pend_q |=> !dead_pend_q)
    else $error("Dead polling raised in point-to-point operation.");

  // Messages are throttled early enough that no push meets a full queue.
  chk_no_overflow: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    push |-> !fifo_full)
    else $error("Response pushed into a full queue.");

  // A meaningful dead polling event arms its report with the right address.
  chk_dead_post: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    poll_dead_i && control_station_i && multipoint_i |=> dead_pend_q && dead_addr_q == $past(poll_dead_addr_i))
    else $error("Dead polling event was not armed.");

  // Ready falls once fewer than two slots are free.
  chk_ready_room: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !fifo_room2 |=> !rx_ready_o)
    else $error("Message port stayed ready with the queue nearly full.");

  // Timeouts before the seventh only count up by one.
  chk_sel_count: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    sel_to && !sel_hit |=> sel_cnt_q[$past(sel_to_addr)] == $past(sel_cnt_q[sel_to_addr]) + `TEV_SEL_CNT_ONE)
    else $error("Selection error counter did not advance.");

  // Maintenance while halted queues its own code.
  chk_maint_halt_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rx_take && rx_msg_i.kind == MSG_MAINT && rx_state == ST_HALTED
    |-> push && push_data.response_code_byte == `TEV_CODE_MAINT_HALT)
    else $error("Maintenance while halted did not post its code.");

endmodule

// ---- sim/remote_station_model.sv ----
// Behavioural remote stations on the line: offer received messages and answer polls.
// Assumes the bench calls its tasks from one process and shares the controller clock.
`timescale 1ns/1ps

module remote_station_model
  import trib_event_pkg::*;
#(
  parameter int SEL_CYC = 8
) (
  input wire logic mclk_i, // Controller clock.
  input wire logic rx_ready_i, // Block can take a message.
  input wire logic halt_i, // Halt pulse from the block.
  input wire logic discard_i, // Discard pulse from the block.
  input wire logic [7:0] halt_addr_i, // Tributary being halted.
  output logic rx_valid_o, // Message offered.
  output rx_msg_type rx_msg_o, // Offered message.
  output logic poll_start_o, // Poll or transmission ended.
  output logic [7:0] poll_addr_o, // Station polled.
  output logic poll_resp_o // Station answered.
);
  // Idle line at time zero.
  initial begin
    rx_valid_o = 1'b0;
    rx_msg_o = '0;
    poll_start_o = 1'b0;
    poll_addr_o = 8'h00;
    poll_resp_o = 1'b0;
  end

  // Offers one message, holds it until taken and returns halt, discard and halted address.
  task automatic send(input logic [7:0] a, input msg_kind_type k, output logic [9:0] ans);
    @(negedge mclk_i);
    rx_valid_o = 1'b1;
    rx_msg_o = '{addr: a, kind: k};
    while (rx_ready_i !== 1'b1) @(negedge mclk_i);
    @(negedge mclk_i);
    // A released line shows the inverse, so a stale copy can never pass for a new message.
    rx_valid_o = 1'b0;
    rx_msg_o = ~rx_msg_o;
    ans = {halt_i, discard_i, (halt_i === 1'b1) ? halt_addr_i : 8'h00};
  endtask

  // Polls a station; it answers inside the interval or stays silent past its end.
  task automatic poll(input logic [7:0] a, input logic answer);
    @(negedge mclk_i);
    poll_start_o = 1'b1;
    poll_addr_o = a;
    @(negedge mclk_i);
    poll_start_o = 1'b0;
    poll_addr_o = ~a;
    if (answer) begin
      @(negedge mclk_i);
      poll_resp_o = 1'b1;
      @(negedge mclk_i);
      poll_resp_o = 1'b0;
    end
    repeat (SEL_CYC + 4) @(negedge mclk_i);
  endtask
endmodule

// ---- sim/tb_tributary_event_response_logic.sv ----
// Self-checking bench for the tributary event response logic.
// Assumes the remote station model drives the line side; the bench plays the host.
`timescale 1ns/1ps
`include "trib_event_defines.svh"

module tb_tributary_event_response_logic;
  import trib_event_pkg::*;
  localparam int SEL = 8; // Short selection interval keeps the run brief.
  logic mclk = 1'b0, rst_n = 1'b0, rx_valid, rx_ready, p_start, p_resp, dead = 1'b0;
  logic cs = 1'b1, mp = 1'b1, st_cmd = 1'b0, ack = 1'b0, lup = 1'b0, halt, disc, rsp_valid, pop = 1'b0;
  logic [7:0] p_addr, dead_addr = 8'h00, cmd_addr = 8'h00, halt_addr;
  rx_msg_type rx_msg;
  event_rsp_type rsp;
  logic [9:0] ans;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;

  always #20 mclk = ~mclk;

  tributary_event_response_logic #(.SEL_INTERVAL_CYC(SEL)) u_tributary_event_response_logic (
    .mclk_i(mclk), .rst_n_i(rst_n), .rx_valid_i(rx_valid), .rx_msg_i(rx_msg), .rx_ready_o(rx_ready),
    .poll_start_i(p_start), .poll_addr_i(p_addr), .poll_resp_i(p_resp), .poll_dead_i(dead),
    .poll_dead_addr_i(dead_addr), .control_station_i(cs), .multipoint_i(mp), .startup_cmd_i(st_cmd),
    .ack_start_i(ack), .link_up_i(lup), .cmd_addr_i(cmd_addr), .halt_o(halt), .halt_addr_o(halt_addr),
    .discard_o(disc), .rsp_valid_o(rsp_valid), .rsp_o(rsp), .rsp_pop_i(pop));

  remote_station_model #(.SEL_CYC(SEL)) u_remote_station_model (
    .mclk_i(mclk), .rx_ready_i(rx_ready), .halt_i(halt), .discard_i(disc), .halt_addr_i(halt_addr),
    .rx_valid_o(rx_valid), .rx_msg_o(rx_msg), .poll_start_o(p_start), .poll_addr_o(p_addr),
    .poll_resp_o(p_resp));

  // Prints the counts and the verdict, then stops the run.
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hang short; the ceiling is about ten times the expected run length.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      results();
    end
  end

  // One comparison with case equality, so an unknown never matches.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits a bounded time for the head response, compares it and pops it.
  task automatic expect_rsp(input logic [7:0] a, input logic [7:0] code);
    int n;
    n = 0;
    // One edge passes first, so back-to-back calls never reassign pop in one step.
    @(negedge mclk);
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
    chk("response", {a, code}, rsp);
    pop = rsp_valid;
    @(negedge mclk);
    pop = 1'b0;
  endtask

  // Lets some cycles pass and checks that nothing was posted.
  task automatic quiet(input int n);
    repeat (n) @(negedge mclk);
    chk("rsp_valid", 16'h0000, {15'h0000, rsp_valid});
  endtask

  // Host state strobe: 0 start-up, 1 start acknowledge, 2 link up.
  task automatic host(input int which, input logic [7:0] a);
    @(negedge mclk);
    cmd_addr = a;
    st_cmd = (which == 0);
    ack = (which == 1);
    lup = (which == 2);
    @(negedge mclk);
    {st_cmd, ack, lup} = 3'h0;
  endtask

  // Halted tributary: maintenance, then two starts in maintenance, all left queued.
  task automatic t_halted();
    u_remote_station_model.send(8'h03, MSG_MAINT, ans);
    chk("maint halted", 16'h0100, {6'h00, ans});
    u_remote_station_model.send(8'h03, MSG_START, ans);
    chk("start maint", 16'h0000, {6'h00, ans});
    u_remote_station_model.send(8'h03, MSG_START, ans);
    expect_rsp(8'h03, `TEV_CODE_MAINT_HALT);
    expect_rsp(8'h03, `TEV_CODE_START_MAINT);
    expect_rsp(8'h03, `TEV_CODE_START_MAINT);
  endtask

  // Running tributary: start halts it, restart, then maintenance halts and discards.
  task automatic t_run();
    for (int i = 0; i < 3; i++) host(i, 8'h05);
    u_remote_station_model.send(8'h05, MSG_START, ans);
    chk("start run", 16'h0205, {6'h00, ans});
    expect_rsp(8'h05, `TEV_CODE_START_RUN);
    for (int i = 0; i < 3; i++) host(i, 8'h05);
    u_remote_station_model.send(8'h05, MSG_MAINT, ans);
    chk("maint run", 16'h0305, {6'h00, ans});
    expect_rsp(8'h05, `TEV_CODE_MAINT_RUN);
    u_remote_station_model.send(8'h05, MSG_START, ans);
    expect_rsp(8'h05, `TEV_CODE_START_MAINT);
  endtask

  // Maintenance in the two start-up states, one tributary each.
  task automatic t_starting();
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i <= s; i++) host(i, 8'h06 + 8'(s));
      u_remote_station_model.send(8'h06 + 8'(s), MSG_MAINT, ans);
      chk("maint start-up", {6'h00, 2'h3, 8'h06 + 8'(s)}, {6'h00, ans});
      expect_rsp(8'h06 + 8'(s), `TEV_CODE_MAINT_RUN);
    end
  endtask

  // Seven timeouts make one error; an answered poll does not count.
  task automatic t_select();
    for (int i = 0; i < 6; i++) u_remote_station_model.poll(8'h09, 1'b0);
    u_remote_station_model.poll(8'h09, 1'b1);
    quiet(4);
    u_remote_station_model.poll(8'h09, 1'b0);
    expect_rsp(8'h09, `TEV_CODE_SEL_THRESH);
    for (int i = 0; i < 6; i++) u_remote_station_model.poll(8'h09, 1'b0);
    quiet(2);
    u_remote_station_model.poll(8'h09, 1'b0);
    expect_rsp(8'h09, `TEV_CODE_SEL_THRESH);
  endtask

  // Dead polling state under every station role and line mode.
  task automatic t_dead();
    for (int m = 0; m < 4; m++) begin
      @(negedge mclk);
      {cs, mp} = 2'(m);
      dead_addr = 8'h21;
      dead = 1'b1;
      @(negedge mclk);
      dead = 1'b0;
      if (m == 3) begin
        expect_rsp(8'h21, `TEV_CODE_POLL_DEAD);
      end else begin
        quiet(6);
      end
    end
  endtask

  // Fills the head and all but one storage slot unread, checks that messages are refused, then drains in order.
  task automatic t_fill();
    for (int i = 0; i < `TEV_FIFO_DEPTH; i++) u_remote_station_model.send(8'h40 + 8'(i), MSG_MAINT, ans);
    @(negedge mclk);
    chk("rx_ready full", 16'h0000, {15'h0000, rx_ready});
    for (int i = 0; i < `TEV_FIFO_DEPTH; i++) expect_rsp(8'h40 + 8'(i), `TEV_CODE_MAINT_HALT);
    quiet(2);
    chk("rx_ready free", 16'h0001, {15'h0000, rx_ready});
  endtask

  // Main sequence: reset for four cycles, then every scenario.
  initial begin
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    t_halted();
    t_run();
    t_starting();
    t_select();
    t_dead();
    t_fill();
    results();
  end
endmodule
